// file: dicp_consts.svh
// Purpose: Constants for the discrete input channel processor
// Assumes: Word-indexed register port, 25 MHz clock
// Notes:   Offsets are word indices on the plain register port
`ifndef DICP_CONSTS_SVH
`define DICP_CONSTS_SVH

// ----------------------------------------------------------------
// Sizes and limits
// ----------------------------------------------------------------
`define DICP_NUM_CH       64
`define DICP_LAST_CH      6'h3F
`define DICP_MAX_SLAVE    4'hB
`define DICP_MB_ADDR_MIN  20'h00001
`define DICP_MB_ADDR_MAX  20'h10000
`define DICP_DELAY_MAX    10'h3E7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DICP_SEC_NS       1000000000
`define DICP_CLK_NS       40
`define DICP_SEC_CYCLES   (`DICP_SEC_NS / `DICP_CLK_NS)

// ----------------------------------------------------------------
// Register map: channel registers at ch*8+field, globals above
// ----------------------------------------------------------------
`define DICP_F_CFG        3'h0
`define DICP_F_NET_ADDR   3'h1
`define DICP_F_OPT        3'h2
`define DICP_F_DELAY      3'h3
`define DICP_F_THRESH     3'h4
`define DICP_F_COUNT      3'h5
`define DICP_F_STATE      3'h6
`define DICP_A_IRQ_STAT   10'h200
`define DICP_A_IRQ_MASK   10'h201

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DICP_CFG_SRC      1:0
`define DICP_CFG_SLAVE    5:2
`define DICP_CFG_COIL     6
`define DICP_CFG_HEX      7
`define DICP_CFG_BASE     11:8
`define DICP_CFG_CHNO     15:12
`define DICP_CFG_AIDX     20:16
`define DICP_CFG_ABIT     27:24
`define DICP_OPT_INV      0
`define DICP_OPT_LOG      1
`define DICP_OPT_MODE     4:2
`define DICP_OPT_CLOG     5
`define DICP_OPT_RST      6
`define DICP_IRQ_STATE    0
`define DICP_IRQ_CNT      1
`define DICP_IRQ_REFUSED  2

// ----------------------------------------------------------------
// Network request kinds and reset values
// ----------------------------------------------------------------
`define DICP_KIND_DI      2'h0
`define DICP_KIND_COIL    2'h1
`define DICP_KIND_SLMP    2'h2
`define DICP_RST_MASK     3'h0

`endif

// file: dicp_pkg.sv
// Purpose: Types for the discrete input channel processor
// Assumes: dicp_consts.svh on the include path
// Notes:   Whole control state is one packed struct
`include "dicp_consts.svh"

package dicp_pkg;

   typedef enum logic [1:0] {
      scan_idle = 2'h0,
      scan_req  = 2'h1,
      scan_upd  = 2'h2
   } dicp_scan_t;

   typedef enum logic [1:0] {
      src_local  = 2'h0,
      src_modbus = 2'h1,
      src_slmp   = 2'h2,
      src_analog = 2'h3
   } dicp_src_t;

   typedef enum logic [2:0] {
      cnt_disabled = 3'h0,
      cnt_on_time  = 3'h1,
      cnt_off_time = 3'h2,
      cnt_rise     = 3'h3,
      cnt_fall     = 3'h4
   } dicp_cnt_mode_t;

   typedef struct packed {
      dicp_scan_t                scan;
      logic [5:0]                ch;
      logic [31:0]               sec_cnt;
      logic                      req_valid;
      logic                      req_ok;
      logic [3:0]                req_slave;
      logic [1:0]                req_kind;
      logic [19:0]               req_addr;
      logic [`DICP_NUM_CH-1:0]   st;
      logic [`DICP_NUM_CH-1:0]   over;
      logic                      ev_st;
      logic                      ev_cnt;
      logic [5:0]                ev_ch;
      logic                      ev_level;
      logic [2:0]                irq_stat;
      logic [2:0]                irq_mask;
      logic                      irq;
      logic [31:0]               rdata;
   } dicp_state_t;

endpackage

// file: dicp_top.sv
// Purpose: Discrete input channel processor with delays and counters
// Assumes: Inputs synchronous to clk; network answers in the same cycle as
//          its request; SEC_CYCLES well above 130
// Notes:   Channels are scanned once per second, two cycles each
//
// Summary of operation
// - Sixty-four channels, each with its own configuration, scanned in order.
// - Local source picks module base and channel, sixteen channels per module.
// - Network sources pick a slave index from 0 to 11.
// - Modbus source reads the input table or the coil table.
// - SLMP device number is decimal or hexadecimal per channel.
// - Analog source takes one selected bit 0 to 15 of its value.
// - Analog source is refused when that analog channel is a pulse input.
// - Invert option complements the raw bit before all processing.
// - With logging on, every processed state change raises an event.
// - Separate ON and OFF delays of 0 to 999 seconds.
// - Counter samples the channel state once every second.
// - Counter modes: off, ON seconds, OFF seconds, rising, falling.
// - Each counter has a 32-bit unsigned event threshold.
// - Reaching threshold with counter logging on raises a counter event.
// - Over-threshold flag is high while the count exceeds the threshold.
// - Reset option clears the count when it reaches the threshold.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "dicp_consts.svh"

module dicp_top #(
   parameter int NUM_MOD    = 16,
   parameter int NUM_AI     = 32,
   parameter int SEC_CYCLES = `DICP_SEC_CYCLES
) (
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic [9:0]               bus_addr,
   input  wire logic [31:0]              bus_wdata,
   input  wire logic                     bus_we,
   input  wire logic                     bus_re,
   output logic      [31:0]              bus_rdata,
   input  wire logic [NUM_MOD*16-1:0]    module_bits,
   input  wire logic [NUM_AI*16-1:0]     analog_values,
   input  wire logic [NUM_AI-1:0]        analog_is_pulse,
   output logic                          net_req_valid,
   output logic      [3:0]               net_req_slave,
   output logic      [1:0]               net_req_kind,
   output logic      [19:0]              net_req_addr,
   input  wire logic                     net_bit,
   output logic      [`DICP_NUM_CH-1:0]  di_state,
   output logic      [`DICP_NUM_CH-1:0]  over_threshold,
   output logic                          state_event,
   output logic                          counter_event,
   output logic      [5:0]               event_channel,
   output logic                          event_level,
   output logic                          irq
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   dicp_pkg::dicp_state_t  s_q;
   dicp_pkg::dicp_state_t  s_d;
   logic [27:0]            cfg_mem  [`DICP_NUM_CH];
   logic [19:0]            net_mem  [`DICP_NUM_CH];
   logic [6:0]             opt_mem  [`DICP_NUM_CH];
   logic [9:0]             on_mem   [`DICP_NUM_CH];
   logic [9:0]             off_mem  [`DICP_NUM_CH];
   logic [31:0]            thr_mem  [`DICP_NUM_CH];
   logic [9:0]             tmr_mem  [`DICP_NUM_CH];
   logic [31:0]            cnt_mem  [`DICP_NUM_CH];

   logic [5:0]             c;
   logic [27:0]            cfg;
   logic [6:0]             opt;
   logic [19:0]            naddr;
   dicp_pkg::dicp_src_t    src;
   logic                   net_src;
   logic                   req_ok;
   logic                   raw_ok;
   logic                   raw;
   logic                   inv_in;
   logic                   cur;
   logic [9:0]             dly;
   logic                   accept;
   logic [9:0]             tmr_d;
   logic                   new_st;
   logic                   inc;
   logic [31:0]            cnt_sum;
   logic                   hit;
   logic [31:0]            cnt_d;
   logic                   tick;
   logic [5:0]             bch;
   logic [2:0]             bf;
   logic                   bus_ch;
   logic [31:0]            rd_val;
   logic [2:0]             stat_set;
   logic [2:0]             stat_clr;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Decimal device numbers arrive as five packed BCD digits
   function automatic logic [19:0] bcd_to_bin(input logic [19:0] v);
      logic [19:0] r;
      r = 20'(v[3:0]) + 20'(v[7:4]) * 20'd10 + 20'(v[11:8]) * 20'd100
        + 20'(v[15:12]) * 20'd1000 + 20'(v[19:16]) * 20'd10000;
      return r;
   endfunction

   function automatic logic [9:0] clamp_delay(input logic [9:0] v);
      return (v > `DICP_DELAY_MAX) ? `DICP_DELAY_MAX : v;
   endfunction

   // ----------------------------------------------------------------
   // Channel decode
   // ----------------------------------------------------------------
   always_comb begin
      c       = s_q.ch;
      cfg     = cfg_mem[c];
      opt     = opt_mem[c];
      naddr   = net_mem[c];
      src     = dicp_pkg::dicp_src_t'(cfg[`DICP_CFG_SRC]);
      net_src = (src == dicp_pkg::src_modbus) ||
                (src == dicp_pkg::src_slmp);
      // Out-of-range slave or address makes the channel refused
      req_ok  = net_src && (cfg[`DICP_CFG_SLAVE] <= `DICP_MAX_SLAVE) &&
                ((src == dicp_pkg::src_slmp) ||
                 ((naddr >= `DICP_MB_ADDR_MIN) &&
                  (naddr <= `DICP_MB_ADDR_MAX)));
      raw_ok  = 1'b0;
      raw     = 1'b0;
      case (src)
         dicp_pkg::src_local: begin
            raw_ok = 32'(cfg[`DICP_CFG_BASE]) < NUM_MOD;
            if (raw_ok) begin
               raw = module_bits[{cfg[`DICP_CFG_BASE],
                                  cfg[`DICP_CFG_CHNO]}];
            end
         end
         dicp_pkg::src_analog: begin
            raw_ok = (32'(cfg[`DICP_CFG_AIDX]) < NUM_AI) &&
                     !analog_is_pulse[cfg[`DICP_CFG_AIDX]];
            if (raw_ok) begin
               raw = analog_values[{cfg[`DICP_CFG_AIDX],
                                    cfg[`DICP_CFG_ABIT]}];
            end
         end
         default: begin
            raw_ok = s_q.req_ok;
            raw    = net_bit;
         end
      endcase
      inv_in  = raw ^ opt[`DICP_OPT_INV];
      cur     = s_q.st[c];
      dly     = inv_in ? on_mem[c] : off_mem[c];
      accept  = 1'b0;
      tmr_d   = 10'h000;
      if (raw_ok && (inv_in != cur)) begin
         // Timer restarts whenever the level falls back
         if (tmr_mem[c] >= dly) begin
            accept = 1'b1;
         end else begin
            tmr_d = tmr_mem[c] + 10'h001;
         end
      end
      new_st  = accept ? inv_in : cur;
      case (dicp_pkg::dicp_cnt_mode_t'(opt[`DICP_OPT_MODE]))
         dicp_pkg::cnt_on_time:  inc = new_st;
         dicp_pkg::cnt_off_time: inc = !new_st;
         dicp_pkg::cnt_rise:     inc = new_st && !cur;
         dicp_pkg::cnt_fall:     inc = !new_st && cur;
         default:                inc = 1'b0;
      endcase
      cnt_sum = cnt_mem[c] + 32'h00000001;
      hit     = inc && (cnt_sum == thr_mem[c]);
      if (opt[`DICP_OPT_MODE] == 3'h0) begin
         cnt_d = 32'h00000000;
      end else if (hit && opt[`DICP_OPT_RST]) begin
         cnt_d = 32'h00000000;
      end else if (inc) begin
         cnt_d = cnt_sum;
      end else begin
         cnt_d = cnt_mem[c];
      end
   end

   // ----------------------------------------------------------------
   // Register read decode
   // ----------------------------------------------------------------
   always_comb begin
      bch    = bus_addr[8:3];
      bf     = bus_addr[2:0];
      bus_ch = !bus_addr[9];
      rd_val = 32'h00000000;
      if (bus_ch) begin
         case (bf)
            `DICP_F_CFG:      rd_val = {4'h0, cfg_mem[bch]};
            `DICP_F_NET_ADDR: rd_val = {12'h000, net_mem[bch]};
            `DICP_F_OPT:      rd_val = {25'h0000000, opt_mem[bch]};
            `DICP_F_DELAY:    rd_val = {6'h00, off_mem[bch],
                                        6'h00, on_mem[bch]};
            `DICP_F_THRESH:   rd_val = thr_mem[bch];
            `DICP_F_COUNT:    rd_val = cnt_mem[bch];
            `DICP_F_STATE:    rd_val = {6'h00, tmr_mem[bch], 14'h0000,
                                        s_q.over[bch], s_q.st[bch]};
            default:          rd_val = 32'h00000000;
         endcase
      end else if (bus_addr == `DICP_A_IRQ_STAT) begin
         rd_val = {29'h00000000, s_q.irq_stat};
      end else if (bus_addr == `DICP_A_IRQ_MASK) begin
         rd_val = {29'h00000000, s_q.irq_mask};
      end
   end

   // ----------------------------------------------------------------
   // Scanner, events and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      s_d           = s_q;
      s_d.req_valid = 1'b0;
      s_d.ev_st     = 1'b0;
      s_d.ev_cnt    = 1'b0;
      stat_set      = 3'h0;
      tick          = s_q.sec_cnt == 32'(SEC_CYCLES - 1);
      s_d.sec_cnt   = tick ? 32'h00000000 : s_q.sec_cnt + 32'h00000001;
      case (s_q.scan)
         dicp_pkg::scan_idle: begin
            if (tick) begin
               s_d.scan = dicp_pkg::scan_req;
               s_d.ch   = 6'h00;
            end
         end
         dicp_pkg::scan_req: begin
            s_d.req_ok    = req_ok;
            s_d.req_valid = req_ok;
            s_d.req_slave = cfg[`DICP_CFG_SLAVE];
            if (src == dicp_pkg::src_slmp) begin
               s_d.req_kind = `DICP_KIND_SLMP;
               s_d.req_addr = cfg[`DICP_CFG_HEX] ? naddr
                                                 : bcd_to_bin(naddr);
            end else begin
               s_d.req_kind = cfg[`DICP_CFG_COIL] ? `DICP_KIND_COIL
                                                  : `DICP_KIND_DI;
               s_d.req_addr = naddr - `DICP_MB_ADDR_MIN;
            end
            s_d.scan = dicp_pkg::scan_upd;
         end
         dicp_pkg::scan_upd: begin
            s_d.st[c]    = new_st;
            s_d.over[c]  = cnt_d > thr_mem[c];
            s_d.ev_st    = accept && opt[`DICP_OPT_LOG];
            s_d.ev_cnt   = hit && opt[`DICP_OPT_CLOG];
            s_d.ev_ch    = c;
            s_d.ev_level = new_st;
            stat_set     = {!raw_ok, s_d.ev_cnt, s_d.ev_st};
            s_d.ch       = c + 6'h01;
            s_d.scan     = (c == `DICP_LAST_CH) ? dicp_pkg::scan_idle
                                                : dicp_pkg::scan_req;
         end
         default: s_d.scan = dicp_pkg::scan_idle;
      endcase
      // Set beats clear so an event in the clearing cycle survives
      stat_clr = (bus_we && (bus_addr == `DICP_A_IRQ_STAT)) ?
                 bus_wdata[2:0] : 3'h0;
      s_d.irq_stat = (s_q.irq_stat & ~stat_clr) | stat_set;
      if (bus_we && (bus_addr == `DICP_A_IRQ_MASK)) begin
         s_d.irq_mask = bus_wdata[2:0];
      end
      s_d.irq   = |(s_d.irq_stat & s_d.irq_mask);
      s_d.rdata = bus_re ? rd_val : 32'h00000000;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q          <= '0;
         s_q.scan     <= dicp_pkg::scan_idle;
         s_q.irq_mask <= `DICP_RST_MASK;
      end else begin
         s_q <= s_d;
      end
   end

   // Configuration writes; channel state updates only in scan_upd
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < `DICP_NUM_CH; i++) begin
            cfg_mem[i] <= 28'h0000000;
            net_mem[i] <= 20'h00000;
            opt_mem[i] <= 7'h00;
            on_mem[i]  <= 10'h000;
            off_mem[i] <= 10'h000;
            thr_mem[i] <= 32'h00000000;
            tmr_mem[i] <= 10'h000;
            cnt_mem[i] <= 32'h00000000;
         end
      end else begin
         if (bus_we && bus_ch) begin
            case (bf)
               `DICP_F_CFG:      cfg_mem[bch] <= bus_wdata[27:0];
               `DICP_F_NET_ADDR: net_mem[bch] <= bus_wdata[19:0];
               `DICP_F_OPT:      opt_mem[bch] <= bus_wdata[6:0];
               `DICP_F_DELAY: begin
                  on_mem[bch]  <= clamp_delay(bus_wdata[9:0]);
                  off_mem[bch] <= clamp_delay(bus_wdata[25:16]);
               end
               `DICP_F_THRESH:   thr_mem[bch] <= bus_wdata;
               default: ;
            endcase
         end
         if (s_q.scan == dicp_pkg::scan_upd) begin
            tmr_mem[c] <= tmr_d;
            cnt_mem[c] <= cnt_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus_rdata      = s_q.rdata;
   assign net_req_valid  = s_q.req_valid;
   assign net_req_slave  = s_q.req_slave;
   assign net_req_kind   = s_q.req_kind;
   assign net_req_addr   = s_q.req_addr;
   assign di_state       = s_q.st;
   assign over_threshold = s_q.over;
   assign state_event    = s_q.ev_st;
   assign counter_event  = s_q.ev_cnt;
   assign event_channel  = s_q.ev_ch;
   assign event_level    = s_q.ev_level;
   assign irq            = s_q.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic       upd_q;
   logic [5:0] upd_ch_q;
   logic       upd_dis_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         upd_q     <= 1'b0;
         upd_ch_q  <= 6'h00;
         upd_dis_q <= 1'b0;
      end else begin
         upd_q     <= s_q.scan == dicp_pkg::scan_upd;
         upd_ch_q  <= c;
         upd_dis_q <= opt[`DICP_OPT_MODE] == 3'h0;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   a_scan_length: assert property (
      (s_q.scan == dicp_pkg::scan_idle) ##1
      (s_q.scan == dicp_pkg::scan_req) |-> ##128
      (s_q.scan == dicp_pkg::scan_idle))
      else $error("channel scan did not take 128 cycles");
   a_slave_range: assert property (
      net_req_valid |-> net_req_slave <= `DICP_MAX_SLAVE)
      else $error("network request with slave above 11");
   a_modbus_addr: assert property (
      net_req_valid && (net_req_kind != `DICP_KIND_SLMP)
      |-> net_req_addr < `DICP_MB_ADDR_MAX)
      else $error("modbus request address out of range");
   a_event_change: assert property (
      state_event |-> (di_state[event_channel] == event_level) &&
      ($past(s_q.st) != s_q.st))
      else $error("state event without a state change");
   a_delay_reset: assert property (
      state_event |-> tmr_mem[event_channel] == 10'h000)
      else $error("delay timer not restarted after change");
   a_over_flag: assert property (
      upd_q |-> over_threshold[upd_ch_q] ==
      (cnt_mem[upd_ch_q] > thr_mem[upd_ch_q]))
      else $error("over-threshold flag disagrees with count");
   a_cnt_reset: assert property (
      counter_event && opt_mem[event_channel][`DICP_OPT_RST]
      |-> cnt_mem[event_channel] == 32'h00000000)
      else $error("counter not cleared at threshold");
   a_cnt_disabled: assert property (
      upd_q && upd_dis_q |-> cnt_mem[upd_ch_q] == 32'h00000000)
      else $error("disabled counter not held at zero");
   a_cnt_event_log: assert property (
      counter_event |-> opt_mem[event_channel][`DICP_OPT_CLOG] &&
      $past(s_q.scan == dicp_pkg::scan_upd))
      else $error("counter event without logging enabled");
   a_irq_level: assert property (
      ##1 (irq == |(s_q.irq_stat & s_q.irq_mask)))
      else $error("interrupt disagrees with status and mask");
   a_read_timing: assert property (
      !bus_re |=> bus_rdata == 32'h00000000)
      else $error("read data outside the answer cycle");

   c_state_event:   cover property (state_event);
   c_counter_event: cover property (counter_event);
   c_refused:       cover property (s_q.irq_stat[`DICP_IRQ_REFUSED]);
   c_irq:           cover property ($rose(irq));

endmodule

// file: dicp_net_slave.sv
// Purpose: Model of the networked slaves answering bit requests
// Assumes: The answer is needed in the cycle of the request
// Notes:   Between requests the line toggles, so no stale bit survives
`timescale 1ns/10ps

module dicp_net_slave (
   input  wire logic        clk,
   input  wire logic        req_valid,
   input  wire logic [3:0]  req_slave,
   input  wire logic [1:0]  req_kind,
   input  wire logic [19:0] req_addr,
   output logic             net_bit
);
   logic tog_q = 1'b0;

   // Plain always: the start value comes from the declaration
   always @(posedge clk) begin
      tog_q <= ~tog_q;
   end

   // Answer hangs on the request itself, never on a held value
   assign net_bit = req_valid ? ^{req_slave, req_kind, req_addr} : tog_q;
endmodule

// file: tb_discrete_input_channel_processor.sv
// Purpose: Self-checking bench for the channel processor
// Assumes: SEC_CYCLES cut to 200, scans start near multiples of 200
// Notes:   Checks land between scans so config never races a scan
`timescale 1ns/10ps

module tb_discrete_input_channel_processor;
   localparam int SEC = 200;
   localparam logic [25:0] NET_EXP = 26'hD00004;
   // Slave 2, SLMP kind, decimal 123 sent as binary
   localparam logic [25:0] SLMP_EXP = 26'hA0007B;
   logic [25:0]  net_got, nx;
   logic         clk, reset, bus_we, bus_re, net_bit, irq, rd_p;
   logic [9:0]   bus_addr;
   logic [31:0]  bus_wdata, bus_rdata, analog_is_pulse;
   logic [255:0] module_bits;
   logic [511:0] analog_values;
   logic         net_req_valid, state_event, counter_event, event_level;
   logic [3:0]   net_req_slave;
   logic [1:0]   net_req_kind;
   logic [19:0]  net_req_addr;
   logic [63:0]  di_state, over_threshold, e;
   logic [5:0]   event_channel;
   logic [63:0]  exp_q[$];
   int           fail_count, comparisons, cyc;

   dicp_top #(.SEC_CYCLES(SEC)) dut_u (.clk, .reset, .bus_addr, .bus_wdata,
      .bus_we, .bus_re, .bus_rdata, .module_bits, .analog_values,
      .analog_is_pulse, .net_req_valid, .net_req_slave, .net_req_kind,
      .net_req_addr, .net_bit, .di_state, .over_threshold, .state_event,
      .counter_event, .event_channel, .event_level, .irq);
   assign net_got = {net_req_slave, net_req_kind, net_req_addr};

   dicp_net_slave peer_u (.clk, .req_valid(net_req_valid),
      .req_slave(net_req_slave), .req_kind(net_req_kind),
      .req_addr(net_req_addr), .net_bit);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   task automatic conclude();
      if (fail_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_we <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_we <= 1'b0;
   endtask

   // Expected word and mask noted before the strobe goes out
   task automatic rd(input logic [9:0] a, input logic [31:0] x,
                     input logic [31:0] m);
      exp_q.push_back({m, x});
      @(posedge clk);
      bus_re <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_re <= 1'b0;
   endtask

   task automatic wait_to(input int n);
      while (cyc < n) @(posedge clk);
   endtask

   // -------------------------------------------------------------
   // Watcher: read data one cycle after the strobe, net requests
   // -------------------------------------------------------------
   always @(posedge clk) begin
      cyc <= reset ? 0 : cyc + 1;
      rd_p <= bus_re;
      if (rd_p) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 64'h0;
         chk((bus_rdata & e[63:32]) === e[31:0], "read data");
      end
      if (net_req_valid) begin
         nx = (net_req_slave == 4'h2) ? SLMP_EXP : NET_EXP;
         chk(net_got === nx, "net");
      end
      if (state_event) begin
         chk(event_channel === 6'h00, "state event channel");
         chk(event_level === ~module_bits[18], "event level");
      end
      if (counter_event)
         chk(event_channel === 6'h00, "counter event channel");
   end

   initial begin
      repeat (1500) @(posedge clk);
      fail_count++;
      conclude();
   end

   initial begin
      reset = 1'b1;
      bus_we = 1'b0;
      bus_re = 1'b0;
      bus_addr = 10'h000;
      bus_wdata = 32'h0;
      void'($urandom(82698));
      for (int i = 0; i < 16; i++) analog_values[i*32 +: 32] = $urandom;
      for (int i = 0; i < 8; i++) module_bits[i*32 +: 32] = $urandom;
      analog_is_pulse = $urandom;
      module_bits[18] = 1'b0;
      analog_values[117] = 1'b1;
      analog_is_pulse[9] = 1'b1;
      analog_is_pulse[7] = 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(10'h3FF, 32'h0, '1);
      rd(10'h1FD, 32'h0, '1);
      wr(10'h000, 32'h0000_2100);
      wr(10'h002, 32'h0000_0067);
      wr(10'h004, 32'h2);
      wr(10'h008, 32'h0000_004D);
      wr(10'h009, 32'h5);
      wr(10'h00A, 32'h1);
      wr(10'h028, 32'h0000_000A);
      wr(10'h029, 32'h0000_0123);
      wr(10'h010, 32'h0009_0003);
      wr(10'h018, 32'h0507_0003);
      wr(10'h01A, 32'h4);
      wr(10'h01C, 32'h1);
      wr(10'h023, 32'h03FF_03FF);
      wr(10'h201, 32'h1);
      rd(10'h002, 32'h67, '1);
      rd(10'h023, 32'h03E7_03E7, '1);
      wait_to(SEC + 150);
      rd(10'h006, 32'h1, 32'h3);
      rd(10'h005, 32'h1, '1);
      rd(10'h01E, 32'h1, 32'h3);
      rd(10'h00E, 32'h1, 32'h1);
      rd(10'h200, 32'h5, '1);
      chk(irq === 1'b1, "irq low");
      wr(10'h200, 32'h5);
      repeat (3) @(posedge clk);
      chk(irq === 1'b0, "irq stuck");
      wait_to(2*SEC + 150);
      rd(10'h005, 32'h0, '1);
      rd(10'h200, 32'h6, '1);
      rd(10'h01E, 32'h3, 32'h3);
      chk(over_threshold[3] === 1'b1, "over flag");
      chk(irq === 1'b0, "masked irq");
      module_bits[18] <= 1'b1;
      wr(10'h003, 32'h0001_0000);
      wait_to(3*SEC + 150);
      chk(di_state[0] === 1'b1, "early off");
      wait_to(4*SEC + 150);
      chk(di_state[0] === 1'b0, "late off");
      repeat (4) @(posedge clk);
      conclude();
   end
endmodule
